/* File: isl_slave.sv */
/*
 * Two-wire bus slave: address match, byte receive and transmit, stretching.
 * Assumes open-drain pins resolved outside; control bits are plain ports.
 */
module isl_slave (
	input  wire logic       clk_sys_in,
	input  wire logic       nrst_in,
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe_out,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	input  wire logic       ten_bit_mode_in,
	input  wire logic       stretch_enable_in,
	input  wire logic       address_hold_enable_in,
	input  wire logic       data_hold_enable_in,
	input  wire logic       buffer_overwrite_enable_in,
	input  wire logic       slave_collision_detect_enable_in,
	input  wire logic       start_event_enable_in,
	input  wire logic       stop_event_enable_in,
	input  wire logic       ack_value_select_in,
	input  wire logic       own_addr_wr_in,
	input  wire logic [7:0] own_addr_data_in,
	input  wire logic       clock_release_set_in,
	input  wire logic       event_flag_clr_in,
	input  wire logic       overflow_clr_in,
	input  wire logic       collision_clr_in,
	input  wire logic       tx_write_in,
	input  wire logic [7:0] tx_data_in,
	output logic            rx_valid_out,
	input  wire logic       rx_ready_in,
	output logic      [7:0] rx_data_out,
	output logic      [7:0] own_address_reg_out,
	output logic            serial_event_flag_out,
	output logic            update_address_flag_out,
	output logic            read_write_out,
	output logic            buffer_full_flag_out,
	output logic            receive_overflow_flag_out,
	output logic            clock_release_bit_out,
	output logic            ack_time_status_out,
	output logic            ack_received_status_out,
	output logic            start_seen_out,
	output logic            stop_seen_out,
	output logic            bus_collision_flag_out
);

	// ==================================================
	// Line synchronisation and edges
	logic [1:0] line_s;
	logic       scl_s;
	logic       sda_s;
	logic       scl_q;
	logic       sda_q;

	isl_sync #(.WIDTH(2)) u_sync (
		.clk_sys_in (clk_sys_in),
		.nrst_in    (nrst_in),
		.d_in       ({scl_in, sda_in}),
		.q_out      (line_s)
	);

	assign scl_s = line_s[1];
	assign sda_s = line_s[0];

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			scl_q <= isl_pkg::LINE_IDLE;
			sda_q <= isl_pkg::LINE_IDLE;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	assign scl_rise  = scl_s & ~scl_q;
	assign scl_fall  = ~scl_s & scl_q;
	assign start_det = sda_q & ~sda_s & scl_s & scl_q;
	assign stop_det  = ~sda_q & sda_s & scl_s & scl_q;

	// ==================================================
	// Controller state
	isl_pkg::isl_state_t st;
	isl_pkg::isl_state_t next_st;
	logic [3:0] bit_cnt;
	logic [3:0] next_bit_cnt;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [7:0] tx_shift_register;
	logic [7:0] next_tx_shift_register;
	logic [7:0] own_addr;
	logic [7:0] next_own_addr;
	logic       is_addr;
	logic       next_is_addr;
	logic       low_stage;
	logic       next_low_stage;
	logic       prior_match;
	logic       next_prior_match;
	logic       lo_miss;
	logic       next_lo_miss;
	logic       hold_used;
	logic       next_hold_used;
	logic       ack_drv;
	logic       next_ack_drv;
	logic       rw;
	logic       next_rw;
	logic       clock_release_bit;
	logic       next_ckp;
	logic       ua;
	logic       next_ua;
	logic       sef;
	logic       next_sef;
	logic       ov;
	logic       next_ov;
	logic       bcl;
	logic       next_bcl;
	logic       ack_time_status;
	logic       next_ack_time_status;
	logic       ack_received_status;
	logic       next_ack_received_status;
	logic       start_seen;
	logic       next_start_seen;
	logic       stop_seen;
	logic       next_stop_seen;
	logic       push;
	logic       next_push;
	logic [7:0] push_data;
	logic [7:0] next_push_data;

	// ==================================================
	// Byte decode
	logic fifo_ready;
	logic full;
	logic nack_cond;
	logic byte_done;
	logic lo_now;
	logic hi_ok;
	logic addr_match;
	logic hold_sel;

	assign full       = ~fifo_ready;
	assign nack_cond  = ov | (full & ~buffer_overwrite_enable_in);
	assign byte_done  = st == isl_pkg::st_recv && scl_fall && bit_cnt == isl_pkg::BYTE_BITS;
	assign lo_now     = ten_bit_mode_in & low_stage;
	assign hi_ok      = shreg[7:3] == isl_pkg::TEN_PREFIX && shreg[2:1] == own_addr[2:1]
		&& (~shreg[0] | prior_match);
	assign addr_match = lo_now ? shreg == own_addr :
		ten_bit_mode_in ? hi_ok : shreg[7:1] == own_addr[7:1];
	assign hold_sel   = is_addr ? address_hold_enable_in : data_hold_enable_in;

	always_comb begin
		next_st                = st;
		next_bit_cnt           = bit_cnt;
		next_shreg             = shreg;
		next_tx_shift_register = tx_write_in ? tx_data_in : tx_shift_register;
		next_own_addr          = own_addr_wr_in ? own_addr_data_in : own_addr;
		next_is_addr           = is_addr;
		next_low_stage         = low_stage;
		next_prior_match       = prior_match;
		next_lo_miss           = lo_miss;
		next_hold_used         = hold_used;
		next_ack_drv           = ack_drv;
		next_rw                = rw;
		next_ckp               = clock_release_bit | clock_release_set_in;
		next_ua                = ua & ~own_addr_wr_in;
		next_sef               = sef & ~event_flag_clr_in;
		next_ov                = ov & ~overflow_clr_in;
		next_bcl               = bcl & ~collision_clr_in;
		next_ack_time_status            = ack_time_status;
		next_ack_received_status           = ack_received_status;
		next_start_seen        = start_seen;
		next_stop_seen         = stop_seen;
		next_push              = 1'b0;
		next_push_data         = push_data;
		unique case (st)
			isl_pkg::st_idle: begin
			end
			isl_pkg::st_recv: begin
				if (scl_rise) begin
					next_shreg   = {shreg[6:0], sda_s};
					next_bit_cnt = bit_cnt + 4'h1;
				end
				if (byte_done) begin
					if (is_addr && ten_bit_mode_in && !low_stage && (!shreg[0] || !hi_ok)) begin
						next_prior_match = 1'b0;
					end
					if (is_addr && !addr_match) begin
						if (lo_now) begin
							next_st      = isl_pkg::st_ack;
							next_ack_drv = 1'b0;
							next_lo_miss = 1'b1;
						end else begin
							next_st = isl_pkg::st_idle;
						end
					end else begin
						if (is_addr) begin
							next_rw = lo_now ? 1'b0 : shreg[0];
						end
						if (full) begin
							next_ov = 1'b1;
						end else begin
							next_push      = 1'b1;
							next_push_data = shreg;
						end
						next_hold_used = hold_sel;
						if (hold_sel) begin
							next_sef    = 1'b1;
							next_ckp    = 1'b0;
							next_ack_time_status = 1'b1;
							next_st     = isl_pkg::st_hold;
						end else begin
							next_ack_drv = ~nack_cond;
							next_st      = isl_pkg::st_ack;
						end
					end
				end
			end
			isl_pkg::st_hold: begin
				if (clock_release_bit) begin
					next_ack_drv = ~ack_value_select_in;
					next_st      = isl_pkg::st_ack;
				end
			end
			isl_pkg::st_ack: begin
				if (scl_fall) begin
					next_ack_time_status  = 1'b0;
					next_bit_cnt = 4'h0;
					next_lo_miss = 1'b0;
					if (lo_miss) begin
						next_sef = 1'b1;
						next_ua  = 1'b1;
						next_st  = isl_pkg::st_idle;
					end else begin
						if (!hold_used || ack_drv) begin
							next_sef = 1'b1;
						end
						if (!ack_drv) begin
							next_st = isl_pkg::st_idle;
						end else if (is_addr && rw) begin
							next_ckp     = 1'b0;
							next_is_addr = 1'b0;
							next_st      = isl_pkg::st_send;
						end else begin
							next_st = isl_pkg::st_recv;
							if (is_addr && ten_bit_mode_in) begin
								next_ua        = 1'b1;
								next_low_stage = ~low_stage;
								next_is_addr   = ~low_stage;
								next_prior_match = prior_match | low_stage;
							end else begin
								next_is_addr = 1'b0;
							end
							if (stretch_enable_in) begin
								next_ckp = 1'b0;
							end
						end
					end
				end
			end
			isl_pkg::st_send: begin
				if (scl_rise && slave_collision_detect_enable_in
					&& tx_shift_register[7] && !sda_s) begin
					next_bcl = 1'b1;
					next_st  = isl_pkg::st_idle;
				end else if (scl_fall) begin
					next_tx_shift_register = {tx_shift_register[6:0], 1'b1};
					next_bit_cnt = bit_cnt + 4'h1;
					if (bit_cnt == isl_pkg::TX_LAST) begin
						next_st = isl_pkg::st_mack;
					end
				end
			end
			isl_pkg::st_mack: begin
				if (scl_rise) begin
					next_ack_received_status = sda_s;
				end
				if (scl_fall) begin
					next_sef     = 1'b1;
					next_bit_cnt = 4'h0;
					if (ack_received_status) begin
						next_st = isl_pkg::st_idle;
					end else begin
						next_ckp = 1'b0;
						next_st  = isl_pkg::st_send;
					end
				end
			end
			default: begin
				next_st = isl_pkg::st_idle;
			end
		endcase
		if (start_det) begin
			next_st         = isl_pkg::st_recv;
			next_bit_cnt    = 4'h0;
			next_is_addr    = 1'b1;
			next_low_stage  = 1'b0;
			next_lo_miss    = 1'b0;
			next_ack_time_status     = 1'b0;
			next_start_seen = 1'b1;
			next_stop_seen  = 1'b0;
			if (start_event_enable_in) begin
				next_sef = 1'b1;
			end
		end else if (stop_det) begin
			next_st          = isl_pkg::st_idle;
			next_stop_seen   = 1'b1;
			next_start_seen  = 1'b0;
			next_prior_match = 1'b0;
			next_ack_time_status      = 1'b0;
			if (stop_event_enable_in) begin
				next_sef = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st                <= isl_pkg::st_idle;
			bit_cnt           <= 4'h0;
			shreg             <= 8'h00;
			tx_shift_register <= 8'hff;
			own_addr          <= isl_pkg::OWN_ADDR_RST;
			is_addr           <= 1'b0;
			low_stage         <= 1'b0;
			prior_match       <= 1'b0;
			lo_miss           <= 1'b0;
			hold_used         <= 1'b0;
			ack_drv           <= 1'b0;
			rw                <= 1'b0;
			clock_release_bit               <= isl_pkg::CKP_RST;
			ua                <= 1'b0;
			sef               <= 1'b0;
			ov                <= 1'b0;
			bcl               <= 1'b0;
			ack_time_status            <= 1'b0;
			ack_received_status           <= 1'b0;
			start_seen        <= 1'b0;
			stop_seen         <= 1'b0;
			push              <= 1'b0;
			push_data         <= 8'h00;
		end else begin
			st                <= next_st;
			bit_cnt           <= next_bit_cnt;
			shreg             <= next_shreg;
			tx_shift_register <= next_tx_shift_register;
			own_addr          <= next_own_addr;
			is_addr           <= next_is_addr;
			low_stage         <= next_low_stage;
			prior_match       <= next_prior_match;
			lo_miss           <= next_lo_miss;
			hold_used         <= next_hold_used;
			ack_drv           <= next_ack_drv;
			rw                <= next_rw;
			clock_release_bit               <= next_ckp;
			ua                <= next_ua;
			sef               <= next_sef;
			ov                <= next_ov;
			bcl               <= next_bcl;
			ack_time_status            <= next_ack_time_status;
			ack_received_status           <= next_ack_received_status;
			start_seen        <= next_start_seen;
			stop_seen         <= next_stop_seen;
			push              <= next_push;
			push_data         <= next_push_data;
		end
	end

	// ==================================================
	// Pin drivers
	logic scl_oe;
	logic next_scl_oe;
	logic sda_oe;
	logic next_sda_oe;

	always_comb begin
		// Keep the clock low until the chosen acknowledge stands on the data line
		next_scl_oe = (~clock_release_bit | ua | st == isl_pkg::st_hold
			| (st == isl_pkg::st_ack && hold_used && sda_oe != ack_drv))
			& (~scl_s | scl_oe);
		next_sda_oe = (st == isl_pkg::st_ack && ack_drv)
			|| (st == isl_pkg::st_send && !tx_shift_register[7]);
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			scl_oe <= next_scl_oe;
			sda_oe <= next_sda_oe;
		end
	end

	// ==================================================
	// Receive buffer
	isl_fifo #(.WIDTH(isl_pkg::DATA_W), .DEPTH(isl_pkg::FIFO_DEPTH)) u_fifo (
		.clk_sys_in    (clk_sys_in),
		.nrst_in       (nrst_in),
		.in_valid_in   (push),
		.in_ready_out  (fifo_ready),
		.in_data_in    (push_data),
		.out_valid_out (rx_valid_out),
		.out_ready_in  (rx_ready_in),
		.out_data_out  (rx_data_out)
	);

	assign scl_out                   = 1'b0;
	assign sda_out                   = 1'b0;
	assign scl_oe_out                = scl_oe;
	assign sda_oe_out                = sda_oe;
	assign own_address_reg_out       = own_addr;
	assign serial_event_flag_out     = sef;
	assign update_address_flag_out   = ua;
	assign read_write_out            = rw;
	assign buffer_full_flag_out      = full;
	assign receive_overflow_flag_out = ov;
	assign clock_release_bit_out     = clock_release_bit;
	assign ack_time_status_out       = ack_time_status;
	assign ack_received_status_out   = ack_received_status;
	assign start_seen_out            = start_seen;
	assign stop_seen_out             = stop_seen;
	assign bus_collision_flag_out    = bcl;

	// ==================================================
	// Checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);

	logic quiet;
	assign quiet = !start_det && !stop_det;

	sequence s_enter_hold;
		st == isl_pkg::st_recv ##1 st == isl_pkg::st_hold;
	endsequence
	sequence s_read_acked;
		st == isl_pkg::st_ack && scl_fall && ack_drv && is_addr && rw && !lo_miss && quiet;
	endsequence

	property p_flag_sticky;
		sef && !event_flag_clr_in |=> sef;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("event flag lost");

	property p_scl_wait;
		$rose(scl_oe) |-> !$past(scl_s);
	endproperty
	a_scl_wait: assert property (p_scl_wait) else $error("clock pulled while high");

	property p_ua_clear;
		own_addr_wr_in && !(st == isl_pkg::st_ack && scl_fall) |=> !ua;
	endproperty
	a_ua_clear: assert property (p_ua_clear) else $error("update flag kept");

	property p_read_hold;
		s_read_acked |=> !clock_release_bit && st == isl_pkg::st_send;
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("read not held");

	property p_miss7;
		byte_done && is_addr && !ten_bit_mode_in && shreg[7:1] != own_addr[7:1] && quiet
			|=> st == isl_pkg::st_idle;
	endproperty
	a_miss7: assert property (p_miss7) else $error("mismatch not idle");

	property p_start;
		start_det |=> st == isl_pkg::st_recv && start_seen && is_addr;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");

	property p_stop;
		stop_det |=> st == isl_pkg::st_idle && stop_seen && !start_seen;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not taken");

	property p_hold;
		s_enter_hold |-> !clock_release_bit && sef && ack_time_status;
	endproperty
	a_hold: assert property (p_hold) else $error("hold entry wrong");

	property p_ack_sel;
		st == isl_pkg::st_hold && clock_release_bit && quiet
			|=> st == isl_pkg::st_ack && ack_drv == !$past(ack_value_select_in);
	endproperty
	a_ack_sel: assert property (p_ack_sel) else $error("ack value wrong");

	property p_tx_event;
		st == isl_pkg::st_mack && scl_fall && quiet |=> sef;
	endproperty
	a_tx_event: assert property (p_tx_event) else $error("no transmit event");

	property p_bcl;
		st == isl_pkg::st_send && scl_rise && slave_collision_detect_enable_in
			&& tx_shift_register[7] && !sda_s && quiet |=> bcl && st == isl_pkg::st_idle;
	endproperty
	a_bcl: assert property (p_bcl) else $error("collision missed");

endmodule : isl_slave

/* File: isl_pkg.sv */
/*
 * Shared constants and state codes of the two-wire bus slave.
 * Assumes a single system clock; bus lines are open drain and idle high.
 */
package isl_pkg;

	// ==================================================
	// Controller states
	typedef enum logic [2:0] {
		st_idle = 3'h0,
		st_recv = 3'h1,
		st_hold = 3'h2,
		st_ack  = 3'h3,
		st_send = 3'h4,
		st_mack = 3'h5
	} isl_state_t;

	// ==================================================
	// Byte framing and addressing
	localparam logic [3:0] BYTE_BITS  = 4'h8;
	localparam logic [3:0] TX_LAST    = 4'h7;
	localparam logic [4:0] TEN_PREFIX = 5'h1e;
	localparam int         DATA_W     = 8;
	localparam int         FIFO_DEPTH = 4;

	// ==================================================
	// Values after reset
	localparam logic [7:0] OWN_ADDR_RST = 8'h00;
	localparam logic       LINE_IDLE    = 1'h1;
	localparam logic       CKP_RST      = 1'h1;

endpackage : isl_pkg

/* File: isl_sync.sv */
/*
 * Two-flop synchroniser for a group of asynchronous levels.
 * Assumes the inputs idle high, as open-drain bus lines do.
 */
module isl_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk_sys_in,
	input  wire logic             nrst_in,
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] meta;

	if (WIDTH < 1) begin : g_chk
		$error("isl_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta  <= {WIDTH{isl_pkg::LINE_IDLE}};
			q_out <= {WIDTH{isl_pkg::LINE_IDLE}};
		end else begin
			meta  <= d_in;
			q_out <= meta;
		end
	end

endmodule : isl_sync

/* File: isl_fifo.sv */
/*
 * Small first-in first-out buffer with valid/ready on both sides.
 * Assumes DEPTH is a power of two of at least two.
 */
module isl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_sys_in,
	input  wire logic             nrst_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             do_push;
	logic             do_pop;

	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
		$error("isl_fifo: DEPTH must be a power of two >= 2");
	end

	assign in_ready_out  = count != (AW + 1)'(DEPTH);
	assign out_valid_out = count != '0;
	assign out_data_out  = mem[rd_ptr];
	assign do_push       = in_valid_in & in_ready_out;
	assign do_pop        = out_valid_out & out_ready_in;

	always_comb begin
		next_wr_ptr = wr_ptr + AW'(do_push);
		next_rd_ptr = rd_ptr + AW'(do_pop);
		next_count  = count + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (do_push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

endmodule : isl_fifo

/* File: isl_master_model.sv */
/*
 * Behavioural bus master: Start, Stop and byte transfers.
 * Assumes the bench resolves both pulled-up lines from all pull-low enables.
 */
module isl_master_model (
	input  wire logic clk_sys_in,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      scl_oe_out,
	output logic      sda_oe_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		scl_oe_out = 1'b0;
		sda_oe_out = 1'b0;
	end

	// ==================================================
	// Bus phases
	task automatic tick();
		repeat (20) @(posedge clk_sys_in);
		#1;
	endtask : tick

	// Release the clock and wait while a slave stretches it
	task automatic rise();
		int n;
		scl_oe_out = 1'b0;
		n = 0;
		while (scl_in !== 1'b1 && n < 20000) begin
			@(posedge clk_sys_in);
			#1;
			n++;
		end
		tick();
	endtask : rise

	task automatic start();
		sda_oe_out = 1'b0;
		tick();
		rise();
		sda_oe_out = 1'b1;
		tick();
		scl_oe_out = 1'b1;
		tick();
	endtask : start

	task automatic stop();
		sda_oe_out = 1'b1;
		tick();
		rise();
		sda_oe_out = 1'b0;
		tick();
	endtask : stop

	task automatic bitx(input logic b, output logic r);
		sda_oe_out = ~b;
		tick();
		rise();
		r = sda_in;
		scl_oe_out = 1'b1;
		tick();
	endtask : bitx

	// Eight bits most significant first, then the acknowledge bit
	task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
			output logic ao);
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(ai, ao);
	endtask : xfer
endmodule : isl_master_model

/* File: isl_slave_test.sv */
/*
 * Self-checking bench of the bus slave against a behavioural master.
 * Assumes pulled-up lines resolved here; software acts between bytes.
 */
module isl_slave_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_sys_in, nrst_in, m_scl, m_sda, s_scl_oe, s_sda_oe, ten, stretch_enable, se, pe;
	logic       wr, rel, clr, ovc, txw, rdy, a, rx_valid, ev, ua, rw, bf, ov, clock_release_bit, ackr, ss, ps;
	logic       at, bc, ah, asel, buffer_overwrite_enable, sbc;
	logic [1:0] pins;
	logic [7:0] own, own_q, txd, q, rx;
	int         err_count, checked;
	logic [7:0] exp_q[$];
	wire        scl = ~(m_scl | s_scl_oe);
	wire        sda = ~(m_sda | s_sda_oe);

	isl_master_model u_m (.clk_sys_in(clk_sys_in), .scl_in(scl), .sda_in(sda),
		.scl_oe_out(m_scl), .sda_oe_out(m_sda));
	isl_slave u_dut (
		.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .scl_in(scl), .scl_out(pins[1]),
		.scl_oe_out(s_scl_oe), .sda_in(sda), .sda_out(pins[0]), .sda_oe_out(s_sda_oe),
		.ten_bit_mode_in(ten), .stretch_enable_in(stretch_enable), .address_hold_enable_in(ah),
		.data_hold_enable_in(ah), .buffer_overwrite_enable_in(buffer_overwrite_enable),
		.slave_collision_detect_enable_in(sbc), .start_event_enable_in(se),
		.stop_event_enable_in(pe), .ack_value_select_in(asel), .own_addr_wr_in(wr),
		.own_addr_data_in(own), .clock_release_set_in(rel), .event_flag_clr_in(clr),
		.overflow_clr_in(ovc), .collision_clr_in(ovc), .tx_write_in(txw), .tx_data_in(txd),
		.rx_valid_out(rx_valid), .rx_ready_in(rdy), .rx_data_out(rx),
		.own_address_reg_out(own_q), .serial_event_flag_out(ev),
		.update_address_flag_out(ua), .read_write_out(rw), .buffer_full_flag_out(bf),
		.receive_overflow_flag_out(ov), .clock_release_bit_out(clock_release_bit),
		.ack_time_status_out(at), .ack_received_status_out(ackr), .start_seen_out(ss),
		.stop_seen_out(ps), .bus_collision_flag_out(bc));

	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end

	// ==================================================
	// Shared tasks
	task automatic cyc();
		@(posedge clk_sys_in);
		#1;
	endtask : cyc

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude

	task automatic set_own(input logic [7:0] v);
		own = v;
		wr = 1'b1;
		cyc();
		wr = 1'b0;
	endtask : set_own

	task automatic go_start();
		se = 1'($urandom);
		clr = 1'b1;
		cyc();
		clr = 1'b0;
		u_m.start();
		chk(ev, se);
		chk(ss, 1'h1);
	endtask : go_start

	task automatic go_stop();
		pe = 1'($urandom);
		{rel, clr} = 2'h3;
		cyc();
		{rel, clr} = 2'h0;
		u_m.stop();
		chk(ps, 1'h1);
		chk(ev, pe);
	endtask : go_stop

	// Release any hold, clear the event flag, then send one byte
	task automatic byte_wr(input logic [7:0] d, input logic ea);
		{rel, clr} = 2'h3;
		cyc();
		{rel, clr} = 2'h0;
		u_m.xfer(d, 1'b1, q, a);
		chk(a, ea);
		if (!ea) begin
			chk(ev, 1'h1);
			exp_q.push_back(d);
		end
	endtask : byte_wr

	// Held byte: software picks the acknowledge once the event shows
	task automatic byte_hold(input logic [7:0] d, input logic nk);
		{rel, clr} = 2'h3;
		cyc();
		{rel, clr} = 2'h0;
		exp_q.push_back(d);
		fork
			u_m.xfer(d, 1'b1, q, a);
			begin
				wait (ev === 1'b1);
				cyc();
				chk(at, 1'h1);
				chk(clock_release_bit, 1'h0);
				asel = nk;
				{rel, clr} = 2'h3;
				cyc();
				{rel, clr} = 2'h0;
			end
		join
		chk(a, nk);
		chk(ev, !nk);
	endtask : byte_hold

	task automatic byte_rd(input logic ma);
		txd = 8'($urandom);
		txw = 1'b1;
		cyc();
		txw = 1'b0;
		{rel, clr} = 2'h3;
		cyc();
		{rel, clr} = 2'h0;
		u_m.xfer(8'hff, ma, q, a);
		chk(q, txd);
		chk(ackr, ma);
		chk(ev, 1'h1);
		chk(s_scl_oe, !ma);
	endtask : byte_rd

	task automatic drain();
		while (exp_q.size() > 0) begin
			chk(rx_valid, 1'h1);
			chk(rx, exp_q.pop_front());
			rdy = 1'b1;
			cyc();
			rdy = 1'b0;
			cyc();
		end
		chk(rx_valid, 1'h0);
	endtask : drain

	// ==================================================
	// Scenarios
	initial begin
		#200000;
		err_count++;
		conclude();
	end

	initial begin
		{nrst_in, ten, stretch_enable, se, pe, wr, rel, clr, ovc, txw, rdy, ah, asel, buffer_overwrite_enable, sbc} = '0;
		own = 8'h54;
		txd = 8'h00;
		err_count = 0;
		checked = 0;
		void'($urandom(45));
		repeat (2) cyc();
		nrst_in = 1'b1;
		repeat (4) cyc();
		chk(clock_release_bit, 1'h1);
		chk(pins, 8'h00);
		set_own(8'h54);
		chk(own_q, 8'h54);
		stretch_enable = 1'b1;
		go_start();
		byte_wr(8'h54, 1'b0);
		chk(rw, 1'h0);
		repeat (2) begin
			byte_wr(8'($urandom), 1'b0);
			chk(clock_release_bit, 1'h0);
		end
		go_stop();
		drain();
		go_start();
		byte_wr(8'h22, 1'b1);
		chk(ev, 1'h0);
		go_stop();
		go_start();
		byte_wr(8'h55, 1'b0);
		chk(rw, 1'h1);
		chk(clock_release_bit, 1'h0);
		byte_rd(1'b0);
		byte_rd(1'b1);
		go_stop();
		sbc = 1'b1;
		go_start();
		byte_wr(8'h55, 1'b0);
		{txd, txw, rel} = {8'hff, 2'h3};
		cyc();
		{txw, rel} = 2'h0;
		u_m.xfer(8'h00, 1'b1, q, a);
		chk(bc, 1'h1);
		chk(s_sda_oe, 1'h0);
		sbc = 1'b0;
		go_stop();
		drain();
		go_start();
		byte_wr(8'h54, 1'b0);
		repeat (3) byte_wr(8'($urandom), 1'b0);
		chk(bf, 1'h1);
		byte_wr(8'h5a, 1'b1);
		chk(ov, 1'h1);
		go_stop();
		go_start();
		byte_wr(8'h54, 1'b1);
		go_stop();
		ovc = 1'b1;
		cyc();
		{ovc, buffer_overwrite_enable} = 2'h1;
		go_start();
		u_m.xfer(8'h54, 1'b1, q, a);
		chk(a, 1'h0);
		chk(ov, 1'h1);
		buffer_overwrite_enable = 1'b0;
		go_stop();
		drain();
		ovc = 1'b1;
		cyc();
		ovc = 1'b0;
		ah = 1'b1;
		go_start();
		byte_hold(8'h54, 1'b0);
		byte_hold(8'($urandom), 1'b0);
		chk(s_scl_oe, 1'h1);
		byte_hold(8'($urandom), 1'b1);
		ah = 1'b0;
		go_stop();
		drain();
		{ten, stretch_enable} = 2'h2;
		set_own(8'h06);
		go_start();
		byte_wr(8'hf6, 1'b0);
		chk(ua, 1'h1);
		chk(s_scl_oe, 1'h1);
		set_own(8'h3c);
		chk(ua, 1'h0);
		byte_wr(8'h3c, 1'b0);
		chk(ua, 1'h1);
		set_own(8'h06);
		go_start();
		byte_wr(8'hf7, 1'b0);
		byte_rd(1'b1);
		go_stop();
		drain();
		conclude();
	end
endmodule : isl_slave_test
